/* File: design/opaddr_core.sv */
// Register-mode operand address generation, arithmetic and condition codes
module opaddr_core
    import opaddr_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic ea_start,
    input wire logic [1:0] ea_mode,
    input wire logic [2:0] ea_reg,
    input wire logic [1:0] ea_dtype,
    output logic ea_busy,
    output logic ea_valid,
    output logic [15:0] ea_addr,
    output logic mem_req,
    output logic [15:0] mem_addr,
    input wire logic [15:0] mem_rdata,
    input wire logic mem_ack,
    input wire logic reg_wr,
    input wire logic [2:0] reg_wr_sel,
    input wire logic [15:0] reg_wr_data,
    output logic [15:0] reg_value,
    input wire logic alu_start,
    input wire logic [1:0] alu_op,
    input wire logic alu_byte,
    input wire logic [15:0] alu_a,
    input wire logic [15:0] alu_b,
    output logic alu_done,
    output logic [15:0] alu_result,
    output logic [15:0] processor_status_register
);
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_FETCH = 2'b01
    } state_e;

    state_e state_q;
    logic [15:0] gpr_q [8];
    logic [15:0] sel_val;
    logic [15:0] step_w;
    logic take;
    logic [15:0] a_q;
    logic [15:0] b_q;
    logic [1:0] op_q;
    logic byte_q;
    logic pend_q;
    alu_if alu_bus ();

    function automatic logic [15:0] step_size(input logic [1:0] dtype,
                                               input logic [1:0] mode,
                                               input logic [2:0] rsel);
        if (mode == MODE_POSTINC && rsel == PC_INDEX) begin
            return STEP_PC;
        end
        return STEP_UNIT << dtype;
    endfunction

    assign sel_val = gpr_q[ea_reg];
    assign step_w = step_size(ea_dtype, ea_mode, ea_reg);
    assign take = ea_start && (state_q == ST_IDLE);

    // Address sequencer
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= ST_IDLE;
            ea_valid <= 1'b0;
            ea_addr <= 16'h0000;
            mem_req <= 1'b0;
            mem_addr <= 16'h0000;
        end else begin
            ea_valid <= 1'b0;
            case (state_q)
                ST_IDLE: begin
                    if (take) begin
                        case (ea_mode)
                            MODE_PREDEC: begin
                                ea_addr <= sel_val - step_w;
                                ea_valid <= 1'b1;
                            end
                            MODE_POSTINC: begin
                                ea_addr <= sel_val;
                                ea_valid <= 1'b1;
                            end
                            MODE_POSTINC_IND: begin
                                mem_addr <= sel_val;
                                mem_req <= 1'b1;
                                state_q <= ST_FETCH;
                            end
                            default: begin
                                ea_addr <= sel_val;
                                ea_valid <= 1'b1;
                            end
                        endcase
                    end
                end
                ST_FETCH: begin
                    if (mem_ack) begin
                        ea_addr <= mem_rdata;
                        ea_valid <= 1'b1;
                        mem_req <= 1'b0;
                        state_q <= ST_IDLE;
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                    mem_req <= 1'b0;
                end
            endcase
        end
    end

    // General register file; the address step wins over a load
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            for (int i = 0; i < 8; i++) begin
                gpr_q[i] <= GPR_RESET;
            end
        end else if (take) begin
            if (ea_mode == MODE_PREDEC) begin
                gpr_q[ea_reg] <= sel_val - step_w;
            end else begin
                gpr_q[ea_reg] <= sel_val + step_w;
            end
        end else if (reg_wr && state_q == ST_IDLE) begin
            gpr_q[reg_wr_sel] <= reg_wr_data;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ea_busy <= 1'b0;
            reg_value <= 16'h0000;
        end else begin
            ea_busy <= take ? (ea_mode == MODE_POSTINC_IND)
                     : (state_q == ST_FETCH && !mem_ack);
            reg_value <= gpr_q[reg_wr_sel];
        end
    end

    // Arithmetic operands latched, result one cycle later
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            a_q <= 16'h0000;
            b_q <= 16'h0000;
            op_q <= OP_ADD;
            byte_q <= 1'b0;
            pend_q <= 1'b0;
        end else begin
            pend_q <= alu_start;
            if (alu_start) begin
                a_q <= alu_a;
                b_q <= alu_b;
                op_q <= alu_op;
                byte_q <= alu_byte;
            end
        end
    end

    assign alu_bus.a = a_q;
    assign alu_bus.b = b_q;
    assign alu_bus.op = op_q;
    assign alu_bus.byte_mode = byte_q;

    alu_unit u_alu (
        .bus(alu_bus.unit)
    );

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            alu_done <= 1'b0;
            alu_result <= 16'h0000;
            processor_status_register <= PSR_RESET;
        end else begin
            alu_done <= pend_q;
            if (pend_q) begin
                alu_result <= alu_bus.result;
                processor_status_register[CC_N] <= alu_bus.n;
                processor_status_register[CC_Z] <= alu_bus.z;
                processor_status_register[CC_V] <= alu_bus.v;
                processor_status_register[CC_C] <= alu_bus.c;
            end
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    a_predec_addr: assert property (
        take && ea_mode == MODE_PREDEC |=> ea_valid
        && ea_addr == 16'($past(sel_val) - $past(step_w))
        && gpr_q[$past(ea_reg)] == ea_addr)
        else $error("pre-decrement address wrong");
    a_step_size: assert property (
        ea_mode == MODE_PREDEC |-> step_w == (16'h0001 << ea_dtype))
        else $error("step size does not follow data type");
    a_postinc_addr: assert property (
        take && ea_mode == MODE_POSTINC |=> ea_valid
        && ea_addr == $past(sel_val)
        && gpr_q[$past(ea_reg)] == 16'($past(sel_val) + $past(step_w)))
        else $error("post-increment address or step wrong");
    a_pc_step: assert property (
        take && ea_mode == MODE_POSTINC && ea_reg == PC_INDEX
        |=> gpr_q[PC_INDEX] == 16'($past(sel_val) + 16'h0002))
        else $error("program counter step not two");
    a_ind_fetch: assert property (
        take && ea_mode == MODE_POSTINC_IND |=> mem_req && !ea_valid
        && mem_addr == $past(sel_val)
        && gpr_q[$past(ea_reg)] == 16'($past(sel_val) + $past(step_w)))
        else $error("indirect pointer fetch wrong");
    a_ind_result: assert property (
        state_q == ST_FETCH && mem_ack
        |=> ea_valid && !mem_req && ea_addr == $past(mem_rdata))
        else $error("indirect operand address wrong");
    // Operands of the finished operation are those seen one edge earlier
    a_byte_sign: assert property (
        alu_done && $past(byte_q) |-> alu_result[15:8] == 8'h00
        && processor_status_register[CC_N] == alu_result[7])
        else $error("byte result or sign wrong");
    a_sub_borrow: assert property (
        alu_done && $past(op_q) == OP_SUB && !$past(byte_q)
        |-> processor_status_register[CC_C] == ($past(a_q) < $past(b_q)))
        else $error("borrow flag wrong");
    a_cc_group: assert property (
        alu_start ##1 !alu_start |=> alu_done
        && processor_status_register[15:4] == 12'h000
        && processor_status_register[CC_Z] == (alu_result == 16'h0000))
        else $error("condition codes not updated");
    a_com_invert: assert property (
        alu_done && $past(op_q) == OP_COM && !$past(byte_q)
        |-> alu_result == ~$past(b_q))
        else $error("complement result wrong");
endmodule

/* File: design/opaddr_pkg.sv */
// Constants shared by the operand address unit and its arithmetic unit
package opaddr_pkg;
    localparam int DATA_W = 16;
    localparam logic [2:0] PC_INDEX = 3'h7;
    // Register addressing modes
    localparam logic [1:0] MODE_PREDEC = 2'h0;
    localparam logic [1:0] MODE_POSTINC = 2'h1;
    localparam logic [1:0] MODE_POSTINC_IND = 2'h2;
    // Operand data types; step size is 1 << type, except STEP_PC (2) for post-increment of PC_INDEX
    localparam logic [1:0] DT_BYTE = 2'h0;
    localparam logic [1:0] DT_WORD = 2'h1;
    localparam logic [1:0] DT_FLOAT = 2'h2;
    localparam logic [1:0] DT_DOUBLE = 2'h3;
    localparam logic [15:0] STEP_UNIT = 16'h0001;
    localparam logic [15:0] STEP_PC = 16'h0002;
    // Arithmetic operations
    localparam logic [1:0] OP_ADD = 2'h0;
    localparam logic [1:0] OP_SUB = 2'h1;
    localparam logic [1:0] OP_COM = 2'h2;
    localparam logic [1:0] OP_MOV = 2'h3;
    // Byte and word operand layout
    localparam int BYTE_SIGN = 7;
    localparam int WORD_SIGN = 15;
    localparam logic [15:0] BYTE_MASK = 16'h00FF;
    localparam logic [15:0] WORD_MASK = 16'hFFFF;
    // Condition code positions in the processor status register
    localparam int CC_C = 0;
    localparam int CC_V = 1;
    localparam int CC_Z = 2;
    localparam int CC_N = 3;
    localparam logic [15:0] PSR_RESET = 16'h0000;
    localparam logic [15:0] GPR_RESET = 16'h0000;
endpackage

/* File: design/alu_if.sv */
// Operand and result bundle between the core and its arithmetic unit
interface alu_if;
    logic [15:0] a;
    logic [15:0] b;
    logic [1:0] op;
    logic byte_mode;
    logic [15:0] result;
    logic n;
    logic z;
    logic v;
    logic c;
    modport core (output a, output b, output op, output byte_mode,
                  input result, input n, input z, input v, input c);
    modport unit (input a, input b, input op, input byte_mode,
                  output result, output n, output z, output v, output c);
endinterface

/* File: design/alu_unit.sv */
// Combinational add, subtract, complement and move with condition codes
module alu_unit
    import opaddr_pkg::*;
(
    alu_if.unit bus
);
    logic [16:0] ext_q;
    logic [15:0] mask;
    logic [15:0] a_m;
    logic [15:0] b_m;
    logic [15:0] res;
    int sb;

    always_comb begin
        mask = bus.byte_mode ? BYTE_MASK : WORD_MASK;
        sb = bus.byte_mode ? BYTE_SIGN : WORD_SIGN;
        a_m = bus.a & mask;
        b_m = bus.b & mask;
        ext_q = 17'h00000;
        res = 16'h0000;
        bus.v = 1'b0;
        bus.c = 1'b0;
        case (bus.op)
            OP_ADD: begin
                ext_q = {1'b0, a_m} + {1'b0, b_m};
                res = ext_q[15:0] & mask;
                // Carry out of the top bit of the operand width
                bus.c = bus.byte_mode ? ext_q[8] : ext_q[16];
                bus.v = (a_m[sb] == b_m[sb]) && (res[sb] != a_m[sb]);
            end
            OP_SUB: begin
                ext_q = {1'b0, a_m} - {1'b0, b_m};
                res = ext_q[15:0] & mask;
                // Borrow shows as the wrapped top bit
                bus.c = ext_q[16];
                bus.v = (a_m[sb] != b_m[sb]) && (res[sb] != a_m[sb]);
            end
            OP_COM: begin
                res = ~bus.b & mask;
                bus.c = 1'b1;
            end
            default: begin
                res = b_m;
            end
        endcase
        bus.result = res;
        bus.n = res[sb];
        bus.z = (res == 16'h0000);
    end
endmodule

/* File: sim/mem_read_model.sv */
// Memory read path model answering pointer-word fetches
module mem_read_model (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic slow,
    input wire logic mem_req,
    input wire logic [15:0] mem_addr,
    output logic mem_ack,
    output logic [15:0] mem_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [15:0] PTR_KEY = 16'h5A5A;
    logic [2:0] wait_q;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            mem_ack <= 1'b0;
            wait_q <= 3'h0;
            mem_rdata <= 16'h0000;
        end else if (mem_req && !mem_ack && (!slow || wait_q == 3'h3)) begin
            mem_ack <= 1'b1;
            wait_q <= 3'h0;
            mem_rdata <= mem_addr ^ PTR_KEY;
        end else begin
            mem_ack <= 1'b0;
            if (mem_req && !mem_ack) begin
                wait_q <= wait_q + 3'h1;
            end
            // Released data lines toggle so stale words never look valid
            mem_rdata <= ~mem_rdata;
        end
    end
endmodule

/* File: sim/operand_address_step_logic_bench.sv */
// Self-checking bench for the operand address unit
module operand_address_step_logic_bench import opaddr_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {
        logic [1:0] m;
        logic [2:0] r;
        logic [1:0] t;
        logic [15:0] i, a, e;
    } ea_row_s;
    typedef struct {
        logic [1:0] o;
        logic b;
        logic [15:0] x, y, r, f;
    } alu_row_s;
    logic clk = 1'b0, reset_n = 1'b0, slow = 1'b0, ea_start = 1'b0;
    logic [1:0] ea_mode = 2'h0, ea_dtype = 2'h0, alu_op = 2'h0;
    logic [2:0] ea_reg = 3'h0, reg_wr_sel = 3'h0;
    logic reg_wr = 1'b0, alu_start = 1'b0, alu_byte = 1'b0;
    logic [15:0] reg_wr_data = 16'h0000, alu_a = 16'h0000, alu_b = 16'h0000;
    logic ea_busy, ea_valid, mem_req, mem_ack, alu_done;
    logic [15:0] ea_addr, mem_addr, mem_rdata, reg_value, alu_result;
    logic [15:0] processor_status_register;
    int n_mismatch = 0, samples_checked = 0;
    ea_row_s ea_tab [15] = '{
        '{2'h0, 3'h1, 2'h1, 16'h0100, 16'h00FE, 16'h00FE},
        '{2'h0, 3'h2, 2'h0, 16'h0100, 16'h00FF, 16'h00FF},
        '{2'h0, 3'h3, 2'h2, 16'h0100, 16'h00FC, 16'h00FC},
        '{2'h0, 3'h4, 2'h3, 16'h0100, 16'h00F8, 16'h00F8},
        '{2'h0, 3'h0, 2'h1, 16'h0000, 16'hFFFE, 16'hFFFE},
        '{2'h1, 3'h1, 2'h0, 16'h0200, 16'h0200, 16'h0201},
        '{2'h1, 3'h5, 2'h3, 16'h0200, 16'h0200, 16'h0208},
        '{2'h1, 3'h6, 2'h2, 16'h0200, 16'h0200, 16'h0204},
        '{2'h1, 3'h7, 2'h0, 16'h0300, 16'h0300, 16'h0302},
        '{2'h1, 3'h7, 2'h3, 16'h0300, 16'h0300, 16'h0302},
        '{2'h2, 3'h2, 2'h1, 16'h0400, 16'h5E5A, 16'h0402},
        '{2'h2, 3'h3, 2'h3, 16'h0400, 16'h5E5A, 16'h0408},
        '{2'h2, 3'h4, 2'h0, 16'h0401, 16'h5E5B, 16'h0402},
        '{2'h2, 3'h7, 2'h2, 16'h0600, 16'h5C5A, 16'h0604},
        '{2'h3, 3'h5, 2'h1, 16'h0700, 16'h0700, 16'h0702}};
    alu_row_s alu_tab [8] = '{
        '{2'h0, 1'b0, 16'hFFFF, 16'h0001, 16'h0000, 16'h0005},
        '{2'h0, 1'b0, 16'h7FFF, 16'h0001, 16'h8000, 16'h000A},
        '{2'h1, 1'b0, 16'h0001, 16'h0002, 16'hFFFF, 16'h0009},
        '{2'h1, 1'b0, 16'h0005, 16'h0005, 16'h0000, 16'h0004},
        '{2'h2, 1'b1, 16'h0000, 16'h00D9, 16'h0026, 16'h0001},
        '{2'h3, 1'b1, 16'h0000, 16'h1280, 16'h0080, 16'h0008},
        '{2'h0, 1'b1, 16'h00FF, 16'h0001, 16'h0000, 16'h0005},
        '{2'h0, 1'b1, 16'h007F, 16'h0001, 16'h0080, 16'h000A}};

    opaddr_core dut (.clk(clk), .reset_n(reset_n), .ea_start(ea_start),
        .ea_mode(ea_mode), .ea_reg(ea_reg), .ea_dtype(ea_dtype),
        .ea_busy(ea_busy), .ea_valid(ea_valid), .ea_addr(ea_addr),
        .mem_req(mem_req), .mem_addr(mem_addr), .mem_rdata(mem_rdata),
        .mem_ack(mem_ack), .reg_wr(reg_wr), .reg_wr_sel(reg_wr_sel),
        .reg_wr_data(reg_wr_data), .reg_value(reg_value),
        .alu_start(alu_start), .alu_op(alu_op), .alu_byte(alu_byte),
        .alu_a(alu_a), .alu_b(alu_b), .alu_done(alu_done),
        .alu_result(alu_result),
        .processor_status_register(processor_status_register));
    mem_read_model mem (.clk(clk), .reset_n(reset_n), .slow(slow),
        .mem_req(mem_req), .mem_addr(mem_addr), .mem_ack(mem_ack),
        .mem_rdata(mem_rdata));

    initial begin
        forever #20 clk = ~clk;
    end

    task automatic cmp_word(string what, logic [15:0] exp, logic [15:0] got);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic cmp_bit(string what, logic exp, logic got);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected %s: expected %b seen %b", what, exp, got);
        end
    endtask

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic do_reset();
        reset_n = 1'b0;
        repeat (6) @(negedge clk);
        cmp_word("ea_addr", 16'h0000, ea_addr);
        cmp_word("psr", PSR_RESET, processor_status_register);
        cmp_bit("ea_valid", 1'b0, ea_valid);
        cmp_bit("mem_req", 1'b0, mem_req);
        reset_n = 1'b1;
        $display("test reset done");
    endtask

    // Loads the register, requests one address, checks address and step
    task automatic run_ea(ea_row_s w, logic poke);
        int n;
        reg_wr = 1'b1;
        reg_wr_sel = w.r;
        reg_wr_data = w.i;
        @(negedge clk);
        reg_wr = 1'b0;
        ea_start = 1'b1;
        {ea_mode, ea_reg, ea_dtype} = {w.m, w.r, w.t};
        @(negedge clk);
        n = 0;
        while (ea_valid !== 1'b1 && n < 20) begin
            ea_start = poke && n < 2;
            cmp_word("mem_addr", w.i, mem_addr);
            cmp_bit("ea_busy", 1'b1, ea_busy);
            @(negedge clk);
            n++;
        end
        ea_start = 1'b0;
        cmp_bit("ea_valid", 1'b1, ea_valid);
        cmp_bit("ea_busy", 1'b0, ea_busy);
        cmp_word("ea_addr", w.a, ea_addr);
        @(negedge clk);
        cmp_bit("ea_valid", 1'b0, ea_valid);
        cmp_word("reg_value", w.e, reg_value);
    endtask

    task automatic run_alu(alu_row_s w);
        {alu_op, alu_byte, alu_a, alu_b} = {w.o, w.b, w.x, w.y};
        alu_start = 1'b1;
        @(negedge clk);
        alu_start = 1'b0;
        @(negedge clk);
        cmp_bit("alu_done", 1'b1, alu_done);
        cmp_word("alu_result", w.r, alu_result);
        cmp_word("psr", w.f, processor_status_register);
        @(negedge clk);
        cmp_bit("alu_done", 1'b0, alu_done);
    endtask

    initial begin
        #(40 * 2000);
        n_mismatch++;
        report_and_stop();
    end

    initial begin
        do_reset();
        foreach (ea_tab[k]) begin
            run_ea(ea_tab[k], 1'b0);
        end
        $display("test address table done");
        foreach (alu_tab[k]) begin
            run_alu(alu_tab[k]);
        end
        $display("test arithmetic table done");
        do_reset();
        // Slow memory with requests arriving while the pointer is fetched
        slow = 1'b1;
        run_ea('{2'h2, 3'h2, 2'h1, 16'h0500, 16'h5F5A, 16'h0502}, 1'b1);
        slow = 1'b0;
        $display("test fetch refusal done");
        // Back-to-back post-increments on one register
        reg_wr = 1'b1;
        reg_wr_sel = 3'h1;
        reg_wr_data = 16'h0010;
        @(negedge clk);
        reg_wr = 1'b0;
        ea_start = 1'b1;
        {ea_mode, ea_reg, ea_dtype} = {2'h1, 3'h1, 2'h1};
        @(negedge clk);
        cmp_word("ea_addr", 16'h0010, ea_addr);
        @(negedge clk);
        ea_start = 1'b0;
        cmp_word("ea_addr", 16'h0012, ea_addr);
        repeat (2) @(negedge clk);
        cmp_word("reg_value", 16'h0014, reg_value);
        $display("test back to back done");
        report_and_stop();
    end
endmodule
